// ---- core/ifsb_consts.vh ----
// constants for the interrupt flag status bank
`ifndef IFSB_CONSTS_VH
`define IFSB_CONSTS_VH

// ==========================================================
// register byte offsets
`define IFSB_OFS_GROUP1 8'h00
`define IFSB_OFS_GROUP2 8'h04
`define IFSB_OFS_GROUP3 8'h08
`define IFSB_OFS_GROUP4 8'h0C
`define IFSB_OFS_IRQ_STAT 8'h10
`define IFSB_OFS_IRQ_MASK 8'h14
`define IFSB_OFS_VARIANT 8'h18

// ==========================================================
// implemented bit masks per flag group
`define IFSB_IMPL_GROUP1 16'h0007
`define IFSB_IMPL_GROUP2 16'h601F
`define IFSB_IMPL_GROUP3 16'h7800
`define IFSB_IMPL_GROUP4 16'hC07E

// ==========================================================
// field positions, group 1
`define IFSB_G1_COMPARATOR 2
`define IFSB_G1_I2C_MASTER 1
`define IFSB_G1_I2C_SLAVE 0
// field positions, group 2
`define IFSB_G2_DMA_CH4 14
`define IFSB_G2_HOST_PORT 13
`define IFSB_G2_DMA_CH3 4
`define IFSB_G2_CAN_EVENT 3
`define IFSB_G2_CAN_RX 2
`define IFSB_G2_SPI2_EVENT 1
`define IFSB_G2_SPI2_ERROR 0
// field positions, group 3
`define IFSB_G3_CALENDAR 14
`define IFSB_G3_DMA_CH5 13
`define IFSB_G3_CODEC_EVENT 12
`define IFSB_G3_CODEC_ERROR 11
// field positions, group 4
`define IFSB_G4_DAC_LEFT 15
`define IFSB_G4_DAC_RIGHT 14
`define IFSB_G4_CAN_TX 6
`define IFSB_G4_DMA_CH7 5
`define IFSB_G4_DMA_CH6 4
`define IFSB_G4_CHECKSUM 3
`define IFSB_G4_UART2_ERROR 2
`define IFSB_G4_UART1_ERROR 1

// ==========================================================
// reset values
`define IFSB_RST_FLAGS 16'h0000
`define IFSB_RST_IRQ 4'h0
`define IFSB_RST_RDATA 32'h00000000

`endif

// ---- core/ifsb_flag_reg.v ----
// one 16-bit interrupt flag register with sticky event set
`timescale 1ns/1ps
`include "ifsb_consts.vh"
module ifsb_flag_reg #(
  parameter [15:0] IMPL_MASK = 16'hFFFF
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire wr_en,
  input wire [15:0] wr_data,
  input wire [15:0] event_in,
  output wire [15:0] flags,
  output wire [15:0] nxt_flags,
  output wire new_set
);

  reg [15:0] flags_ff;

  // ==========================================================
  // next value: software write, then event set on top
  // unimplemented positions forced to zero on every path
  assign nxt_flags = ((wr_en ? wr_data : flags_ff) | event_in) & IMPL_MASK;
  assign new_set = |(event_in & IMPL_MASK);
  assign flags = flags_ff;

  // ==========================================================
  // storage
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_ff <= `IFSB_RST_FLAGS;
    end else if (ce) begin
      flags_ff <= nxt_flags;
    end
  end

endmodule

// ---- core/ifsb_bank.v ----
// interrupt flag status bank with AHB-Lite register slave
// Operation
// - flag reads 1 after its request occurred
// - flags read/write by software, reset zero
// - unimplemented bits ignore writes, read zero
// - group1: comparator bit2, i2c master/slave 1/0
// - group2: dma4 bit14, host port bit13
// - group2 low: dma3, can, can rx, spi2
// - group3: calendar, dma5, codec event, codec error
// - group4: dac left bit15, right bit14
// - group4 low: can tx, dma7/6, crc, uarts
// - no can controller: can sources never raise
// - no audio dac: dac sources never raise
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "ifsb_consts.vh"
module ifsb_bank #(
  parameter HAS_CAN = 1,
  parameter HAS_DAC = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  output wire irq,
  // event pulses from peripherals, same clock
  input wire comparator_event,
  input wire i2c_master_event,
  input wire i2c_slave_event,
  input wire dma_ch4_done,
  input wire parallel_host_port_event,
  input wire dma_ch3_done,
  input wire can_event,
  input wire can_rx_ready,
  input wire second_spi_event,
  input wire second_spi_error,
  input wire calendar_clock_event,
  input wire dma_ch5_done,
  input wire codec_serial_event,
  input wire codec_serial_error,
  input wire audio_dac_left_event,
  input wire audio_dac_right_event,
  input wire can_tx_request,
  input wire dma_ch7_done,
  input wire dma_ch6_done,
  input wire checksum_generator_event,
  input wire second_uart_error,
  input wire first_uart_error,
  // flag register contents for the priority logic
  output wire [15:0] irq_flags_group1,
  output wire [15:0] irq_flags_group2,
  output wire [15:0] irq_flags_group3,
  output wire [15:0] irq_flags_group4
);

  localparam [0:0] CAN_ON = (HAS_CAN != 0) ? 1'b1 : 1'b0;
  localparam [0:0] DAC_ON = (HAS_DAC != 0) ? 1'b1 : 1'b0;

  // ==========================================================
  // variant gating of sources
  // tied off by parameter so absent peripherals never raise a flag
  wire can_ev_g;
  wire can_rx_g;
  wire can_tx_g;
  wire dac_l_g;
  wire dac_r_g;

  assign can_ev_g = can_event & CAN_ON;
  assign can_rx_g = can_rx_ready & CAN_ON;
  assign can_tx_g = can_tx_request & CAN_ON;
  assign dac_l_g = audio_dac_left_event & DAC_ON;
  assign dac_r_g = audio_dac_right_event & DAC_ON;

  // ==========================================================
  // variant readback: which gated source families are present
  wire [1:0] variant_bits;

  assign variant_bits = {DAC_ON, CAN_ON};

  // ==========================================================
  // event vectors placed at their flag positions
  // unlisted positions stay zero; the flag registers mask them again
  reg [15:0] ev_g1;
  reg [15:0] ev_g2;
  reg [15:0] ev_g3;
  reg [15:0] ev_g4;

  always @* begin
    ev_g1 = 16'h0000;
    ev_g1[`IFSB_G1_COMPARATOR] = comparator_event;
    ev_g1[`IFSB_G1_I2C_MASTER] = i2c_master_event;
    ev_g1[`IFSB_G1_I2C_SLAVE] = i2c_slave_event;
    ev_g2 = 16'h0000;
    ev_g2[`IFSB_G2_DMA_CH4] = dma_ch4_done;
    ev_g2[`IFSB_G2_HOST_PORT] = parallel_host_port_event;
    ev_g2[`IFSB_G2_DMA_CH3] = dma_ch3_done;
    ev_g2[`IFSB_G2_CAN_EVENT] = can_ev_g;
    ev_g2[`IFSB_G2_CAN_RX] = can_rx_g;
    ev_g2[`IFSB_G2_SPI2_EVENT] = second_spi_event;
    ev_g2[`IFSB_G2_SPI2_ERROR] = second_spi_error;
    ev_g3 = 16'h0000;
    ev_g3[`IFSB_G3_CALENDAR] = calendar_clock_event;
    ev_g3[`IFSB_G3_DMA_CH5] = dma_ch5_done;
    ev_g3[`IFSB_G3_CODEC_EVENT] = codec_serial_event;
    ev_g3[`IFSB_G3_CODEC_ERROR] = codec_serial_error;
    ev_g4 = 16'h0000;
    ev_g4[`IFSB_G4_DAC_LEFT] = dac_l_g;
    ev_g4[`IFSB_G4_DAC_RIGHT] = dac_r_g;
    ev_g4[`IFSB_G4_CAN_TX] = can_tx_g;
    ev_g4[`IFSB_G4_DMA_CH7] = dma_ch7_done;
    ev_g4[`IFSB_G4_DMA_CH6] = dma_ch6_done;
    ev_g4[`IFSB_G4_CHECKSUM] = checksum_generator_event;
    ev_g4[`IFSB_G4_UART2_ERROR] = second_uart_error;
    ev_g4[`IFSB_G4_UART1_ERROR] = first_uart_error;
  end

  // ==========================================================
  // ahb-lite address phase capture
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;
  wire acc;
  wire rd_acc;
  wire wr_acc;
  wire addr_hi;

  // hsize and htrans[0] are not decoded: single whole-word transfers only
  assign acc = hsel & hready & htrans[1];
  assign addr_hi = |haddr[31:8];
  assign rd_acc = acc & ~hwrite;
  assign wr_acc = acc & hwrite;

  // ==========================================================
  // write strobes in the data phase
  wire wr_g1;
  wire wr_g2;
  wire wr_g3;
  wire wr_g4;
  wire wr_stat;
  wire wr_mask;

  assign wr_g1 = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_GROUP1);
  assign wr_g2 = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_GROUP2);
  assign wr_g3 = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_GROUP3);
  assign wr_g4 = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_GROUP4);
  assign wr_stat = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_IRQ_STAT);
  assign wr_mask = wr_pend_ff & (wr_addr_ff == `IFSB_OFS_IRQ_MASK);

  // ==========================================================
  // the four flag registers
  // only the low half word of hwdata reaches the flags
  wire [15:0] fl_g1;
  wire [15:0] fl_g2;
  wire [15:0] fl_g3;
  wire [15:0] fl_g4;
  wire [15:0] nx_g1;
  wire [15:0] nx_g2;
  wire [15:0] nx_g3;
  wire [15:0] nx_g4;
  wire [3:0] grp_set;

  ifsb_flag_reg #(.IMPL_MASK(`IFSB_IMPL_GROUP1)) u_group1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_g1),
    .wr_data(hwdata[15:0]),
    .event_in(ev_g1),
    .flags(fl_g1),
    .nxt_flags(nx_g1),
    .new_set(grp_set[0])
  );

  ifsb_flag_reg #(.IMPL_MASK(`IFSB_IMPL_GROUP2)) u_group2 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_g2),
    .wr_data(hwdata[15:0]),
    .event_in(ev_g2),
    .flags(fl_g2),
    .nxt_flags(nx_g2),
    .new_set(grp_set[1])
  );

  ifsb_flag_reg #(.IMPL_MASK(`IFSB_IMPL_GROUP3)) u_group3 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_g3),
    .wr_data(hwdata[15:0]),
    .event_in(ev_g3),
    .flags(fl_g3),
    .nxt_flags(nx_g3),
    .new_set(grp_set[2])
  );

  ifsb_flag_reg #(.IMPL_MASK(`IFSB_IMPL_GROUP4)) u_group4 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_g4),
    .wr_data(hwdata[15:0]),
    .event_in(ev_g4),
    .flags(fl_g4),
    .nxt_flags(nx_g4),
    .new_set(grp_set[3])
  );

  assign irq_flags_group1 = fl_g1;
  assign irq_flags_group2 = fl_g2;
  assign irq_flags_group3 = fl_g3;
  assign irq_flags_group4 = fl_g4;

  // ==========================================================
  // interrupt status (write one to clear) and mask
  reg [3:0] irq_stat_ff;
  reg [3:0] irq_mask_ff;
  reg irq_ff;
  wire [3:0] stat_clr;
  wire [3:0] nxt_irq_stat;
  wire [3:0] nxt_irq_mask;
  wire nxt_irq;

  // a new event in the clearing cycle keeps its bit set
  assign stat_clr = wr_stat ? hwdata[3:0] : 4'h0;
  assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | grp_set;
  assign nxt_irq_mask = wr_mask ? hwdata[3:0] : irq_mask_ff;
  // level output, one cycle behind status and mask
  assign nxt_irq = |(irq_stat_ff & irq_mask_ff);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_ff <= `IFSB_RST_IRQ;
      irq_mask_ff <= `IFSB_RST_IRQ;
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================
  // read mux on next values so a read right after a write sees it
  reg [31:0] nxt_rdata;

  always @* begin
    case (haddr[7:0])
      `IFSB_OFS_GROUP1: nxt_rdata = {16'h0000, nx_g1};
      `IFSB_OFS_GROUP2: nxt_rdata = {16'h0000, nx_g2};
      `IFSB_OFS_GROUP3: nxt_rdata = {16'h0000, nx_g3};
      `IFSB_OFS_GROUP4: nxt_rdata = {16'h0000, nx_g4};
      `IFSB_OFS_IRQ_STAT: nxt_rdata = {28'h0000000, nxt_irq_stat};
      `IFSB_OFS_IRQ_MASK: nxt_rdata = {28'h0000000, nxt_irq_mask};
      `IFSB_OFS_VARIANT: nxt_rdata = {30'h0, variant_bits};
      default: nxt_rdata = `IFSB_RST_RDATA;
    endcase
    // nothing is mapped above the decoded byte range
    if (addr_hi) begin
      nxt_rdata = `IFSB_RST_RDATA;
    end
  end

  // ==========================================================
  // bus state
  // zero wait states: hreadyout and hresp hold their reset values
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= `IFSB_RST_RDATA;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (ce) begin
      wr_pend_ff <= wr_acc & ~addr_hi;
      if (wr_acc) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (rd_acc) begin
        hrdata_ff <= nxt_rdata;
      end
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign irq = irq_ff;

endmodule

// ---- bench/ifsb_bank_props.sv ----
// port assertions for the interrupt flag status bank
`timescale 1ns/1ps
module ifsb_bank_props #(
  parameter HAS_CAN = 1,
  parameter HAS_DAC = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ce,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire irq,
  input wire comparator_event,
  input wire dma_ch4_done,
  input wire can_rx_ready,
  input wire codec_serial_error,
  input wire audio_dac_left_event,
  input wire first_uart_error,
  input wire [15:0] irq_flags_group1,
  input wire [15:0] irq_flags_group2,
  input wire [15:0] irq_flags_group3,
  input wire [15:0] irq_flags_group4
);
  // ==========================================================
  // helpers
  wire [63:0] all_flags;
  reg wr_dph_ff;
  assign all_flags = {irq_flags_group4, irq_flags_group3, irq_flags_group2, irq_flags_group1};
  // high during the data phase of an accepted write
  always @(posedge ref_clk) begin
    if (ce) wr_dph_ff <= rst_n & hsel & hready & htrans[1] & hwrite;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or error");
  property p_reset;
    disable iff (1'b0) (!rst_n && ce) |=> (all_flags == 64'h0000000000000000) && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");
  property p_unimpl;
    ((all_flags & ~64'hC07E7800601F0007) == 64'h0000000000000000) && (hrdata[31:16] == 16'h0000);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
  property p_cmp_set;
    ce && comparator_event |=> irq_flags_group1[2];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator flag not set");
  property p_dma4_set;
    ce && dma_ch4_done |=> irq_flags_group2[14];
  endproperty
  a_dma4_set: assert property (p_dma4_set) else $error("dma4 flag not set");
  property p_canrx_set;
    (HAS_CAN != 0) && ce && can_rx_ready |=> irq_flags_group2[2];
  endproperty
  a_canrx_set: assert property (p_canrx_set) else $error("can rx flag not set");
  property p_codec_set;
    ce && codec_serial_error |=> irq_flags_group3[11];
  endproperty
  a_codec_set: assert property (p_codec_set) else $error("codec error flag not set");
  property p_dacl_set;
    (HAS_DAC != 0) && ce && audio_dac_left_event |=> irq_flags_group4[15];
  endproperty
  a_dacl_set: assert property (p_dacl_set) else $error("dac left flag not set");
  property p_uart1_set;
    ce && first_uart_error |=> ##0 irq_flags_group4[1];
  endproperty
  a_uart1_set: assert property (p_uart1_set) else $error("uart1 error flag not set");
  property p_can_gate;
    (HAS_CAN == 0) && !wr_dph_ff |=> !$rose(irq_flags_group2[3]);
  endproperty
  a_can_gate: assert property (p_can_gate) else $error("absent can source raised");
  property p_dac_gate;
    (HAS_DAC == 0) && !wr_dph_ff |=> !$rose(irq_flags_group4[14]);
  endproperty
  a_dac_gate: assert property (p_dac_gate) else $error("absent dac source raised");
  property p_sticky;
    ((~all_flags & $past(all_flags)) != 64'h0000000000000000) |-> $past(wr_dph_ff);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared without write");
  c_irq: cover property ($rose(irq));
  c_clash: cover property (ce && dma_ch4_done && wr_dph_ff);
  c_clear: cover property ((~all_flags & $past(all_flags)) != 64'h0000000000000000);
endmodule

bind ifsb_bank ifsb_bank_props #(.HAS_CAN(HAS_CAN), .HAS_DAC(HAS_DAC)) u_ifsb_bank_props (
  .ref_clk, .rst_n, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .irq, .comparator_event, .dma_ch4_done, .can_rx_ready, .codec_serial_error,
  .audio_dac_left_event, .first_uart_error, .irq_flags_group1, .irq_flags_group2,
  .irq_flags_group3, .irq_flags_group4);

// ---- bench/ifsb_periph_model.sv ----
// peripheral event source model
`timescale 1ns/1ps
module ifsb_periph_model (
  input wire ref_clk,
  input wire [21:0] req,
  output reg [21:0] ev
);
  initial ev = 22'h000000;
  // each request bit is copied to its event a clock later, for as long as it is held
  always @(posedge ref_clk) begin
    ev <= req;
  end
endmodule

// ---- bench/test_ifsb_bank.sv ----
// testbench for the interrupt flag status bank
`timescale 1ns/1ps
module test_ifsb_bank;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg ce = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h00000000;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'b010;
  reg [31:0] hwdata = 32'h00000000;
  reg [21:0] req = 22'h000000;
  wire [21:0] ev;
  wire hready;
  wire hresp;
  wire irq;
  wire [31:0] hrdata;
  wire [63:0] b_flags;
  wire [31:0] b_rd;
  integer fails = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer g;
  integer b;
  integer i;
  reg [31:0] rd;
  reg [15:0] impl [0:3];
  // sources absent on the reduced variant
  localparam [21:0] GATED = 22'h01C0C0;
  always #12.5 ref_clk = ~ref_clk;
  ifsb_periph_model u_ifsb_periph_model (.ref_clk(ref_clk), .req(req), .ev(ev));
  ifsb_bank u_ifsb_bank (.ref_clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .irq,
    .comparator_event(ev[0]), .i2c_master_event(ev[1]), .i2c_slave_event(ev[2]),
    .dma_ch4_done(ev[3]), .parallel_host_port_event(ev[4]), .dma_ch3_done(ev[5]),
    .can_event(ev[6]), .can_rx_ready(ev[7]), .second_spi_event(ev[8]),
    .second_spi_error(ev[9]), .calendar_clock_event(ev[10]), .dma_ch5_done(ev[11]),
    .codec_serial_event(ev[12]), .codec_serial_error(ev[13]), .audio_dac_left_event(ev[14]),
    .audio_dac_right_event(ev[15]), .can_tx_request(ev[16]), .dma_ch7_done(ev[17]),
    .dma_ch6_done(ev[18]), .checksum_generator_event(ev[19]), .second_uart_error(ev[20]),
    .first_uart_error(ev[21]), .irq_flags_group1(), .irq_flags_group2(),
    .irq_flags_group3(), .irq_flags_group4());
  ifsb_bank #(.HAS_CAN(0), .HAS_DAC(0)) u_ifsb_bank_b (.ref_clk, .rst_n, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(), .hresp(), .hrdata(b_rd), .irq(),
    .comparator_event(ev[0]), .i2c_master_event(ev[1]), .i2c_slave_event(ev[2]),
    .dma_ch4_done(ev[3]), .parallel_host_port_event(ev[4]), .dma_ch3_done(ev[5]),
    .can_event(ev[6]), .can_rx_ready(ev[7]), .second_spi_event(ev[8]),
    .second_spi_error(ev[9]), .calendar_clock_event(ev[10]), .dma_ch5_done(ev[11]),
    .codec_serial_event(ev[12]), .codec_serial_error(ev[13]), .audio_dac_left_event(ev[14]),
    .audio_dac_right_event(ev[15]), .can_tx_request(ev[16]), .dma_ch7_done(ev[17]),
    .dma_ch6_done(ev[18]), .checksum_generator_event(ev[19]), .second_uart_error(ev[20]),
    .first_uart_error(ev[21]), .irq_flags_group1(b_flags[15:0]),
    .irq_flags_group2(b_flags[31:16]), .irq_flags_group3(b_flags[47:32]),
    .irq_flags_group4(b_flags[63:48]));
  // ==========================================================
  // single transfer; events in m land at the data-phase edge
  task bus(input w, input [31:0] a, input [31:0] d, input [21:0] m, output [31:0] r);
    begin
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      req <= m;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      htrans <= 2'b00;
      hwdata <= d;
      req <= 22'h000000;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      r = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    impl[0] = 16'h0007;
    impl[1] = 16'h601F;
    impl[2] = 16'h7800;
    impl[3] = 16'hC07E;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (g = 0; g < 6; g = g + 1) begin
      bus(0, 4 * g, 0, 0, rd);
      chk(rd, 0);
    end
    bus(0, 32'h00000018, 0, 0, rd);
    chk(rd, 32'h00000003);
    chk(b_rd, 0);
    bus(1, 32'h00000100, 32'hFFFFFFFF, 0, rd);
    bus(0, 32'h00000100, 0, 0, rd);
    chk(rd, 0);
    for (g = 0; g < 4; g = g + 1) begin
      bus(1, 4 * g, 32'hFFFFFFFF, 0, rd);
      bus(0, 4 * g, 0, 0, rd);
      chk(rd, {16'h0000, impl[g]});
      bus(1, 4 * g, 0, 0, rd);
      bus(0, 4 * g, 0, 0, rd);
      chk(rd, 0);
    end
    i = 0;
    for (g = 0; g < 4; g = g + 1) begin
      for (b = 15; b >= 0; b = b - 1) begin
        if (impl[g][b]) begin
          bus(0, 32'h00000100, 0, 22'h000001 << i, rd);
          bus(0, 4 * g, 0, 0, rd);
          chk(rd, 32'h00000001 << b);
          chk(b_flags[16 * g +: 16], GATED[i] ? 0 : 32'h00000001 << b);
          bus(1, 4 * g, 0, 0, rd);
          bus(0, 4 * g, 0, 0, rd);
          chk(rd, 0);
          i = i + 1;
        end
      end
    end
    bus(1, 32'h00000010, 32'h0000000F, 0, rd);
    bus(1, 32'h00000014, 32'h00000002, 0, rd);
    bus(0, 32'h00000100, 0, 22'h000001, rd);
    bus(0, 32'h00000010, 0, 0, rd);
    chk(rd, 32'h00000001);
    chk(irq, 0);
    // dma4 event meets a clearing write
    bus(1, 32'h00000004, 0, 22'h000008, rd);
    bus(0, 32'h00000004, 0, 0, rd);
    chk(rd, 32'h00004000);
    chk(irq, 1);
    bus(1, 32'h00000010, 32'h00000002, 0, rd);
    bus(0, 32'h00000010, 0, 0, rd);
    chk(rd, 32'h00000001);
    chk(irq, 0);
    bus(1, 32'h00000014, 32'h00000003, 0, rd);
    bus(0, 32'h00000014, 0, 0, rd);
    chk(rd, 32'h00000003);
    chk(irq, 1);
    // an event while the clock enable is low is not taken
    @(posedge ref_clk);
    ce <= 1'b0;
    req <= 22'h020000;
    @(posedge ref_clk);
    req <= 22'h000000;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b1;
    bus(0, 32'h0000000C, 0, 0, rd);
    chk(rd, 0);
    end_sim;
  end
endmodule
